// File: inc/cmdi_pkg.sv
// Constants, bus records and state record of the CAN data and irq block
package cmdi_pkg;
	localparam int NOBJ = 32;
	localparam int NBYTE = 8;
	// Register offsets
	localparam logic [7:0] A_CODE_L = 8'h08;
	localparam logic [7:0] A_CODE_H = 8'h09;
	localparam logic [7:0] A_PAY0 = 8'h10;
	localparam logic [7:0] A_CFG = 8'h20;
	localparam logic [7:0] A_STAT = 8'h21;
	localparam logic [7:0] A_SEL = 8'h24;
	localparam logic [7:0] A_OCTL = 8'h25;
	localparam logic [7:0] A_TREQ0 = 8'h80;
	localparam logic [7:0] A_NDAT0 = 8'h90;
	localparam logic [7:0] A_PEND0 = 8'ha0;
	localparam logic [7:0] A_VLD0 = 8'hb0;
	// Field positions
	localparam int CFG_EN = 0;
	localparam int CFG_LVL = 1;
	localparam int STAT_LEC = 0;
	localparam int STAT_TX_SUCCESS_FLAG = 3;
	localparam int STAT_RX_SUCCESS_FLAG = 4;
	localparam int SEL_CLR = 7;
	localparam int OCTL_TX_REQUEST_FLAG = 0;
	localparam int OCTL_RXIE = 2;
	localparam int OCTL_TXIE = 3;
	localparam int OCTL_PEND = 5;
	localparam int OCTL_VLD = 6;
	localparam int OCTL_NDAT = 7;
	// Values
	localparam logic [15:0] CODE_NONE = 16'h0000;
	localparam logic [15:0] CODE_STAT = 16'h8000;
	localparam logic [3:0] DLC_MAX = 4'h8;
	localparam logic [6:0] BITS_MAX = 7'h40;
	localparam logic [7:0] RD_IDLE = 8'h00;
	localparam logic IRQ_RST = 1'h1;

	typedef enum logic {TX_IDLE, TX_SHIFT} cmdi_tx_e;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} cmdi_bus_s;

	// Protocol core events
	typedef struct packed {
		logic stat_wr;
		logic rx_ok;
		logic tx_ok;
		logic [2:0] last_error_field;
		logic tx_done;
		logic rx_done;
		logic remote;
		logic [4:0] obj;
	} cmdi_core_s;

	// Serial payload strobes from the core
	typedef struct packed {
		logic tx_start;
		logic tx_shift;
		logic [3:0] payload_length_code;
		logic rx_valid;
		logic rx_bit;
	} cmdi_ser_s;

	typedef struct packed {
		logic [NBYTE-1:0][7:0] payload;
		logic [NOBJ-1:0] pend;
		logic [NOBJ-1:0] tx_request_flag;
		logic [NOBJ-1:0] txie;
		logic [NOBJ-1:0] rxie;
		logic [NOBJ-1:0] ndat;
		logic [NOBJ-1:0] vld;
		logic stat_pend;
		logic line_en;
		logic lvl_sel;
		logic rx_ok;
		logic tx_ok;
		logic [2:0] last_error_field;
		logic [4:0] sel;
		logic clr_acc;
		logic [15:0] code;
		logic [7:0] rdata;
		logic irq;
		logic [63:0] txsh;
		logic [6:0] txcnt;
		cmdi_tx_e txst;
		logic tx_bit;
		logic [63:0] rxsh;
	} cmdi_state_s;
endpackage : cmdi_pkg

// File: rtl/cmdi_top.sv
// CAN payload buffers, request flags and interrupt identification
module cmdi_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire cmdi_pkg::cmdi_bus_s bus,
	output logic [7:0] rd_data,
	input wire cmdi_pkg::cmdi_core_s core,
	input wire cmdi_pkg::cmdi_ser_s ser,
	output logic tx_bit,
	output logic tx_busy,
	output logic controller_irq_output
);
	cmdi_pkg::cmdi_state_s s_reg;
	cmdi_pkg::cmdi_state_s s_next;
	logic [15:0] code_next;
	logic [7:0] rd_next;
	logic [1:0] grp;

	assign grp = bus.addr[1:0];

	// Single next-state process for the whole block
	always_comb begin
		s_next = s_reg;
		code_next = cmdi_pkg::CODE_NONE;
		rd_next = cmdi_pkg::RD_IDLE;

		// Fixed priority encoder, lowest object wins
		for (int i = cmdi_pkg::NOBJ - 1; i >= 0; i--) begin
			if (s_reg.pend[i]) begin
				code_next = 16'(i + 1);
			end
		end
		if (s_reg.stat_pend) begin
			code_next = cmdi_pkg::CODE_STAT;
		end
		// Updated even while the line is disabled
		s_next.code = code_next;

		// Line level follows the select bit
		if (s_reg.line_en && code_next != cmdi_pkg::CODE_NONE) begin
			s_next.irq = s_reg.lvl_sel;
		end else begin
			s_next.irq = !s_reg.lvl_sel;
		end

		// Read mux; flag bank addresses take no writes, the flags are written only through A_OCTL
		if (bus.re) begin
			if (bus.addr[7:3] == cmdi_pkg::A_PAY0[7:3]) begin
				rd_next = s_reg.payload[bus.addr[2:0]];
			end else if (bus.addr[7:2] == cmdi_pkg::A_TREQ0[7:2]) begin
				rd_next = s_reg.tx_request_flag[8 * grp +: 8];
			end else if (bus.addr[7:2] == cmdi_pkg::A_NDAT0[7:2]) begin
				rd_next = s_reg.ndat[8 * grp +: 8];
			end else if (bus.addr[7:2] == cmdi_pkg::A_PEND0[7:2]) begin
				rd_next = s_reg.pend[8 * grp +: 8];
			end else if (bus.addr[7:2] == cmdi_pkg::A_VLD0[7:2]) begin
				rd_next = s_reg.vld[8 * grp +: 8];
			end else begin
				case (bus.addr)
					cmdi_pkg::A_CODE_L: begin
						rd_next = s_reg.code[7:0];
					end
					cmdi_pkg::A_CODE_H: begin
						rd_next = s_reg.code[15:8];
					end
					cmdi_pkg::A_CFG: begin
						rd_next[cmdi_pkg::CFG_EN] = s_reg.line_en;
						rd_next[cmdi_pkg::CFG_LVL] = s_reg.lvl_sel;
					end
					cmdi_pkg::A_STAT: begin
						rd_next[cmdi_pkg::STAT_LEC +: 3] = s_reg.last_error_field;
						rd_next[cmdi_pkg::STAT_TX_SUCCESS_FLAG] = s_reg.tx_ok;
						rd_next[cmdi_pkg::STAT_RX_SUCCESS_FLAG] = s_reg.rx_ok;
					end
					cmdi_pkg::A_SEL: begin
						rd_next[4:0] = s_reg.sel;
						rd_next[cmdi_pkg::SEL_CLR] = s_reg.clr_acc;
					end
					cmdi_pkg::A_OCTL: begin
						rd_next[cmdi_pkg::OCTL_TX_REQUEST_FLAG] = s_reg.tx_request_flag[s_reg.sel];
						rd_next[cmdi_pkg::OCTL_RXIE] = s_reg.rxie[s_reg.sel];
						rd_next[cmdi_pkg::OCTL_TXIE] = s_reg.txie[s_reg.sel];
						rd_next[cmdi_pkg::OCTL_PEND] = s_reg.pend[s_reg.sel];
						rd_next[cmdi_pkg::OCTL_VLD] = s_reg.vld[s_reg.sel];
						rd_next[cmdi_pkg::OCTL_NDAT] = s_reg.ndat[s_reg.sel];
					end
					default: begin
						rd_next = cmdi_pkg::RD_IDLE;
					end
				endcase
			end
		end
		// Data stands one cycle only, zero otherwise
		s_next.rdata = rd_next;

		// Software writes to plain registers
		if (bus.we) begin
			if (bus.addr[7:3] == cmdi_pkg::A_PAY0[7:3]) begin
				s_next.payload[bus.addr[2:0]] = bus.wdata;
			end
			case (bus.addr)
				cmdi_pkg::A_CFG: begin
					s_next.line_en = bus.wdata[cmdi_pkg::CFG_EN];
					s_next.lvl_sel = bus.wdata[cmdi_pkg::CFG_LVL];
				end
				cmdi_pkg::A_STAT: begin
					// Touches only the fields, never stat_pend
					s_next.last_error_field = bus.wdata[cmdi_pkg::STAT_LEC +: 3];
					s_next.tx_ok = bus.wdata[cmdi_pkg::STAT_TX_SUCCESS_FLAG];
					s_next.rx_ok = bus.wdata[cmdi_pkg::STAT_RX_SUCCESS_FLAG];
				end
				cmdi_pkg::A_SEL: begin
					s_next.sel = bus.wdata[4:0];
					s_next.clr_acc = bus.wdata[cmdi_pkg::SEL_CLR];
				end
				default: begin
				end
			endcase
		end

		// Per-object flags; hardware events come last so a set wins
		for (int i = 0; i < cmdi_pkg::NOBJ; i++) begin
			if (s_reg.sel == 5'(i)) begin
				if (bus.we && bus.addr == cmdi_pkg::A_OCTL) begin
					s_next.tx_request_flag[i] = bus.wdata[cmdi_pkg::OCTL_TX_REQUEST_FLAG];
					s_next.rxie[i] = bus.wdata[cmdi_pkg::OCTL_RXIE];
					s_next.txie[i] = bus.wdata[cmdi_pkg::OCTL_TXIE];
					s_next.pend[i] = bus.wdata[cmdi_pkg::OCTL_PEND];
					s_next.vld[i] = bus.wdata[cmdi_pkg::OCTL_VLD];
					s_next.ndat[i] = bus.wdata[cmdi_pkg::OCTL_NDAT];
				end
				// Read and release the object in one access
				if (bus.re && bus.addr == cmdi_pkg::A_OCTL && s_reg.clr_acc) begin
					s_next.pend[i] = 1'b0;
				end
			end
			if (core.obj == 5'(i)) begin
				if (core.tx_done) begin
					s_next.tx_request_flag[i] = 1'b0;
					if (s_reg.txie[i]) begin
						s_next.pend[i] = 1'b1;
					end
				end
				if (core.rx_done) begin
					s_next.ndat[i] = 1'b1;
					if (s_reg.rxie[i]) begin
						s_next.pend[i] = 1'b1;
					end
				end
				if (core.remote) begin
					s_next.tx_request_flag[i] = 1'b1;
				end
			end
		end

		// Status interrupt: read clears, core write sets it while the line is enabled and wins
		if (bus.re && bus.addr == cmdi_pkg::A_STAT) begin
			s_next.stat_pend = 1'b0;
		end
		if (core.stat_wr) begin
			s_next.rx_ok = core.rx_ok;
			s_next.tx_ok = core.tx_ok;
			s_next.last_error_field = core.last_error_field;
			if (s_reg.line_en) begin
				s_next.stat_pend = 1'b1;
			end
		end

		// Transmit shifter, byte 0 loaded into the top bits
		case (s_reg.txst)
			cmdi_pkg::TX_IDLE: begin
				if (ser.tx_start && ser.payload_length_code != 4'h0) begin
					for (int b = 0; b < cmdi_pkg::NBYTE; b++) begin
						s_next.txsh[63 - 8 * b -: 8] = s_reg.payload[b];
					end
					if (ser.payload_length_code > cmdi_pkg::DLC_MAX) begin
						s_next.txcnt = cmdi_pkg::BITS_MAX;
					end else begin
						s_next.txcnt = {ser.payload_length_code, 3'h0};
					end
					s_next.txst = cmdi_pkg::TX_SHIFT;
				end
			end
			cmdi_pkg::TX_SHIFT: begin
				if (ser.tx_shift) begin
					s_next.tx_bit = s_reg.txsh[63];
					s_next.txsh = {s_reg.txsh[62:0], 1'b0};
					s_next.txcnt = s_reg.txcnt - 7'h01;
					if (s_reg.txcnt == 7'h01) begin
						s_next.txst = cmdi_pkg::TX_IDLE;
					end
				end
			end
			default: begin
				s_next.txst = cmdi_pkg::TX_IDLE;
			end
		endcase

		// Receive shifter; cleared on each frame, so short frames leave zero top bits
		if (ser.rx_valid) begin
			s_next.rxsh = {s_reg.rxsh[62:0], ser.rx_bit};
		end
		if (core.rx_done) begin
			for (int b = 0; b < cmdi_pkg::NBYTE; b++) begin
				s_next.payload[b] = s_reg.rxsh[63 - 8 * b -: 8];
			end
			s_next.rxsh = '0;
		end
	end

	// State register, synchronous reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.irq <= cmdi_pkg::IRQ_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data = s_reg.rdata;
	assign tx_bit = s_reg.tx_bit;
	assign tx_busy = s_reg.txst == cmdi_pkg::TX_SHIFT;
	assign controller_irq_output = s_reg.irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Identifier checks
	idle_code_a: assert property (
		!s_reg.stat_pend && s_reg.pend == '0 |=> s_reg.code == 16'h0000)
		else $error("code not zero while idle");
	stat_first_a: assert property (
		s_reg.stat_pend |=> s_reg.code == 16'h8000)
		else $error("status not ranked first");
	obj_one_a: assert property (
		!s_reg.stat_pend && s_reg.pend[0] |=> s_reg.code == 16'h0001)
		else $error("object one not ranked first");

	// Output line checks
	irq_active_a: assert property (
		s_reg.line_en && (s_reg.stat_pend || s_reg.pend != '0)
		|=> controller_irq_output == $past(s_reg.lvl_sel))
		else $error("line not at active level");
	irq_off_a: assert property (
		!s_reg.line_en |=> controller_irq_output != $past(s_reg.lvl_sel))
		else $error("line active while disabled");

	// Status interrupt checks
	stat_read_a: assert property (
		bus.re && bus.addr == 8'h21 && !core.stat_wr |=> !s_reg.stat_pend)
		else $error("status read did not clear");
	stat_raise_a: assert property (
		core.stat_wr && s_reg.line_en |=> s_reg.stat_pend ##1 s_reg.code == 16'h8000)
		else $error("core status write not flagged");
	stat_cpu_a: assert property (
		bus.we && bus.addr == 8'h21 && !core.stat_wr && !bus.re
		|=> s_reg.stat_pend == $past(s_reg.stat_pend))
		else $error("software write moved status irq");

	// Object flag and data path checks
	rx_pend_a: assert property (
		core.rx_done && s_reg.rxie[core.obj] |=> s_reg.pend[$past(core.obj)])
		else $error("rx pending not set");
	remote_req_a: assert property (
		core.remote |=> s_reg.tx_request_flag[$past(core.obj)])
		else $error("remote match did not request");
	rx_store_a: assert property (
		core.rx_done |=> s_reg.payload[7] == $past(s_reg.rxsh[7:0]))
		else $error("last byte not stored");
	tx_first_a: assert property (
		s_reg.txst == cmdi_pkg::TX_IDLE && ser.tx_start && ser.payload_length_code != 4'h0
		##1 ser.tx_shift |=> tx_bit == $past(s_reg.payload[0][7], 2))
		else $error("first bit not byte 0 msb");

	// Read-only banks; pending flags only drop on a software action
	bank_ro_a: assert property (
		bus.we && bus.addr[7:2] == cmdi_pkg::A_PEND0[7:2]
		&& !core.rx_done && !core.tx_done
		|=> s_reg.pend == $past(s_reg.pend))
		else $error("pending bank took a write");
	pend_hold_a: assert property (
		!bus.we && !bus.re
		|=> (s_reg.pend & $past(s_reg.pend)) == $past(s_reg.pend))
		else $error("pending flag dropped without software");
	stat_hold_a: assert property (
		s_reg.stat_pend && !(bus.re && bus.addr == cmdi_pkg::A_STAT)
		|=> s_reg.stat_pend)
		else $error("status irq dropped without a read");
	clr_access_a: assert property (
		bus.re && bus.addr == cmdi_pkg::A_OCTL && s_reg.clr_acc
		&& !core.rx_done && !core.tx_done
		|=> !s_reg.pend[$past(s_reg.sel)])
		else $error("access did not release object");

	// Identifier range and hand-over to the next object
	code_range_a: assert property (
		s_reg.code <= 16'h0020 || s_reg.code == cmdi_pkg::CODE_STAT)
		else $error("identifier in unused range");
	code_next_a: assert property (
		!s_reg.stat_pend && !s_reg.pend[0] && s_reg.pend[1]
		|=> s_reg.code == 16'h0002)
		else $error("identifier missed next object");
	code_dark_a: assert property (
		!s_reg.line_en && !s_reg.stat_pend && s_reg.pend[4:0] == 5'h10
		|=> s_reg.code == 16'h0005)
		else $error("identifier frozen while line off");

	// Enables gate the pending flag; a send drops the request
	tx_pend_a: assert property (
		core.tx_done && s_reg.txie[core.obj]
		|=> s_reg.pend[$past(core.obj)])
		else $error("tx pending not set");
	rx_refuse_a: assert property (
		core.rx_done && !core.tx_done && !s_reg.rxie[core.obj]
		&& !s_reg.pend[core.obj] && !(bus.we && bus.addr == cmdi_pkg::A_OCTL)
		|=> !s_reg.pend[$past(core.obj)])
		else $error("rx pending set while disabled");
	tx_request_flag_done_a: assert property (
		core.tx_done && !core.remote |=> !s_reg.tx_request_flag[$past(core.obj)])
		else $error("transmit request kept after send");

	// Byte order and length clamp at the shifters
	rx_first_a: assert property (
		core.rx_done |=> s_reg.payload[0] == $past(s_reg.rxsh[63:56]))
		else $error("first byte not stored in slot 0");
	tx_load_a: assert property (
		s_reg.txst == cmdi_pkg::TX_IDLE && ser.tx_start && ser.payload_length_code != 4'h0
		|=> s_reg.txsh[7:0] == $past(s_reg.payload[7]))
		else $error("last byte not loaded last");
	tx_clamp_a: assert property (
		s_reg.txst == cmdi_pkg::TX_IDLE && ser.tx_start
		&& ser.payload_length_code > cmdi_pkg::DLC_MAX |=> s_reg.txcnt == cmdi_pkg::BITS_MAX)
		else $error("long length code not clamped");
endmodule : cmdi_top

// File: sim/cmdi_core_model.sv
// Protocol core model: event pulses and serial payload bits
module cmdi_core_model (
	input wire logic clk,
	output cmdi_pkg::cmdi_core_s core,
	output cmdi_pkg::cmdi_ser_s ser,
	input wire logic tx_bit
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet until a task asks for traffic
	initial begin
		core = '0;
		ser = '0;
	end
	// One-cycle event: 0 rx, 1 tx, 2 remote, 3 status write
	task ev(input int k, input logic [4:0] o);
		@(posedge clk);
		core <= '{(k == 3), (k == 3), 1'b0, 3'h0, (k == 1), (k == 0),
			(k == 2), o};
		@(posedge clk);
		core <= '0;
	endtask : ev
	// Frame bits go out MSB first, byte 0 first
	task rx(input logic [63:0] f);
		for (int i = 63; i >= 0; i--) begin
			@(posedge clk);
			ser.rx_valid <= 1'b1;
			ser.rx_bit <= f[i];
		end
		@(posedge clk);
		ser.rx_valid <= 1'b0;
		ser.rx_bit <= ~f[0]; // Released line keeps no stale bit
	endtask : rx
	// Start, then keep shift high for n bits and collect them
	task tx(input logic [3:0] d, input int n, output logic [63:0] g);
		g = '0;
		@(posedge clk);
		ser.payload_length_code <= d;
		ser.tx_start <= 1'b1;
		@(posedge clk);
		ser.tx_start <= 1'b0;
		ser.tx_shift <= 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk);
			if (i == 0) begin
				ser.tx_shift <= 1'b0;
			end
			#1 g[i] = tx_bit;
		end
	endtask : tx
endmodule : cmdi_core_model

// File: sim/tb_top.sv
// Testbench for the CAN payload and interrupt identification block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk;
	logic rst_n;
	cmdi_pkg::cmdi_bus_s b;
	logic [7:0] rd_data;
	cmdi_pkg::cmdi_core_s core;
	cmdi_pkg::cmdi_ser_s ser;
	logic tx_bit;
	logic tx_busy;
	logic irq;
	logic [7:0] d;
	logic [63:0] g;
	int err_count;
	int compares;
	localparam logic [63:0] PAT = 64'h1122334455667788;
	localparam logic [63:0] RXF = 64'h0123456789abcdef;

	cmdi_top uut (.clk(clk), .rst_n(rst_n), .bus(b), .rd_data(rd_data),
		.core(core), .ser(ser), .tx_bit(tx_bit), .tx_busy(tx_busy),
		.controller_irq_output(irq));
	cmdi_core_model core_m (.clk(clk), .core(core), .ser(ser),
		.tx_bit(tx_bit));

	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task end_sim();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	task cmp(input logic [63:0] gv, input logic [63:0] ev);
		compares++;
		if (gv !== ev) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, gv, ev);
		end
	endtask : cmp

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		b <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		b <= '0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge clk);
		b <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		b <= '0;
		#1 d = rd_data;
	endtask : rd

	task chk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		cmp(d, e);
	endtask : chk

	// Flag, then code: let both edges land first
	task code(input logic [15:0] e);
		repeat (3) @(posedge clk);
		chk(cmdi_pkg::A_CODE_L, e[7:0]);
		chk(cmdi_pkg::A_CODE_H, e[15:8]);
	endtask : code

	initial begin
		rst_n = 1'b0;
		b = '0;
		err_count = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			chk(cmdi_pkg::A_PAY0 + 8'(i), 8'h00);
		end
		code(16'h0000);
		cmp(irq, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wr(cmdi_pkg::A_PAY0 + 8'(i), PAT[63-8*i -: 8]);
		end
		for (int i = 0; i < 8; i++) begin
			chk(cmdi_pkg::A_PAY0 + 8'(i), PAT[63-8*i -: 8]);
		end
		// Length code 9 must still give exactly 64 bits
		core_m.tx(4'h9, 64, g);
		cmp(g, PAT);
		repeat (2) @(posedge clk);
		#1 cmp(tx_busy, 1'b0);
		// Receive enables on objects 2 and 5, none on 3
		wr(cmdi_pkg::A_SEL, 8'h01);
		wr(cmdi_pkg::A_OCTL, 8'h04);
		wr(cmdi_pkg::A_SEL, 8'h04);
		wr(cmdi_pkg::A_OCTL, 8'h04);
		wr(cmdi_pkg::A_CFG, 8'h01);
		core_m.ev(0, 5'd4);
		core_m.ev(0, 5'd2);
		code(16'h0005);
		core_m.ev(0, 5'd1);
		code(16'h0002);
		cmp(irq, 1'b0);
		chk(cmdi_pkg::A_PEND0, 8'h12);
		wr(cmdi_pkg::A_PEND0, 8'hff);
		chk(cmdi_pkg::A_PEND0, 8'h12);
		core_m.ev(3, 5'd0);
		code(16'h8000);
		wr(cmdi_pkg::A_STAT, 8'h00);
		code(16'h8000);
		rd(cmdi_pkg::A_STAT);
		cmp(d, 8'h00);
		code(16'h0002);
		wr(cmdi_pkg::A_SEL, 8'h81);
		rd(cmdi_pkg::A_OCTL);
		cmp(d, 8'ha4);
		code(16'h0005);
		chk(cmdi_pkg::A_PEND0, 8'h10);
		// Line disabled: no status code, but code still tracks
		wr(cmdi_pkg::A_CFG, 8'h00);
		core_m.ev(3, 5'd0);
		code(16'h0005);
		cmp(irq, 1'b1);
		wr(cmdi_pkg::A_SEL, 8'h84);
		rd(cmdi_pkg::A_OCTL);
		cmp(d, 8'ha4);
		code(16'h0000);
		wr(cmdi_pkg::A_CFG, 8'h03);
		core_m.ev(0, 5'd1);
		code(16'h0002);
		cmp(irq, 1'b1);
		wr(cmdi_pkg::A_CFG, 8'h02);
		repeat (3) @(posedge clk);
		#1 cmp(irq, 1'b0);
		// Received frame lands byte 0 first in the buffer
		core_m.rx(RXF);
		core_m.ev(0, 5'd1);
		for (int i = 0; i < 8; i++) begin
			chk(cmdi_pkg::A_PAY0 + 8'(i), RXF[63-8*i -: 8]);
		end
		core_m.ev(2, 5'd2);
		chk(cmdi_pkg::A_TREQ0, 8'h04);
		core_m.ev(1, 5'd2);
		chk(cmdi_pkg::A_TREQ0, 8'h00);
		wr(cmdi_pkg::A_SEL, 8'h00);
		wr(cmdi_pkg::A_OCTL, 8'h01);
		chk(cmdi_pkg::A_TREQ0, 8'h01);
		// Transmit irq enable: a sent object raises pending
		wr(cmdi_pkg::A_OCTL, 8'h49);
		core_m.ev(1, 5'd0);
		code(16'h0001);
		chk(cmdi_pkg::A_TREQ0, 8'h00);
		chk(cmdi_pkg::A_VLD0, 8'h01);
		chk(cmdi_pkg::A_NDAT0, 8'h16);
		chk(cmdi_pkg::A_CFG, 8'h02);
		// One-byte frame: only byte 0 goes out
		core_m.tx(4'h1, 8, g);
		cmp(g, 64'h01);
		repeat (2) @(posedge clk);
		#1 cmp(tx_busy, 1'b0);
		// Second reset mid-run: buffers, code and line back to idle
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk(cmdi_pkg::A_PAY0, 8'h00);
		code(16'h0000);
		cmp(irq, 1'b1);
		end_sim();
	end

	// Tests take about 400 cycles; cut a hang well past that
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_sim();
	end
endmodule : tb_top
